/* File: tps_prescaler.v */
// Shared prescaler between timer0 input and watchdog output
`timescale 1ns/1ps
`include "tps_consts.vh"

module tps_prescaler #(
	parameter CNT_W = `TPS_CNT_W
)(
	clk,
	rst,
	ce,
	option_nibble,
	timer0_src_tick,
	wdog_src_tick,
	timer0_count_register_write,
	watchdog_clear_instruction,
	timer0_tick,
	wdog_tick,
	watchdog_timer_clear
);
	input wire clk;
	input wire rst;
	input wire ce;
	input wire [`TPS_OPT_W-1:0] option_nibble;
	input wire timer0_src_tick;
	input wire wdog_src_tick;
	input wire timer0_count_register_write;
	input wire watchdog_clear_instruction;
	output reg timer0_tick;
	output reg wdog_tick;
	output reg watchdog_timer_clear;

	// ****************************************
	// Option decode
	// ****************************************
	wire prescaler_owner_select;
	wire [2:0] prescale_ratio_select;
	wire own_wdog;
	wire own_timer0;
	wire timer0_clr;
	wire wdog_clr;
	wire src_tick;
	wire clr;
	wire [CNT_W:0] tap;
	wire [3:0] sel;
	wire div_hit;
	wire timer0_tick_nxt;
	wire wdog_tick_nxt;
	wire watchdog_timer_clear_nxt;
	reg [CNT_W-1:0] cnt_r;
	reg [CNT_W-1:0] cnt_nxt;
	reg [3:0] sel_timer0;
	reg [3:0] sel_wdog;

	assign prescaler_owner_select =
		option_nibble[`TPS_OPT_OWNER_BIT];
	assign prescale_ratio_select =
		option_nibble[`TPS_OPT_RATIO_HI:`TPS_OPT_RATIO_LO];
	assign own_wdog = (prescaler_owner_select == `TPS_OWNER_WDOG);
	assign own_timer0 = ~own_wdog;

	// ****************************************
	// Source and clear steering
	// ****************************************
	// Only the owner's source feeds the counter
	assign src_tick = own_wdog ? wdog_src_tick : timer0_src_tick;

	// Each clear cause only counts for its own owner
	assign timer0_clr = own_timer0 & timer0_count_register_write;
	assign wdog_clr = own_wdog & watchdog_clear_instruction;
	// Clearing is the only way to change the count besides ticking
	assign clr = timer0_clr | wdog_clr;

	// ****************************************
	// Ratio to tap index, per owner
	// ****************************************
	// Timer0 sees one extra halving, so its column is one tap higher
	always @*
	begin
		sel_timer0 = 4'h1;
		sel_wdog = 4'h0;
		case (prescale_ratio_select)
			3'h0:
			begin
				sel_timer0 = 4'h1;
				sel_wdog = 4'h0;
			end
			3'h1:
			begin
				sel_timer0 = 4'h2;
				sel_wdog = 4'h1;
			end
			3'h2:
			begin
				sel_timer0 = 4'h3;
				sel_wdog = 4'h2;
			end
			3'h3:
			begin
				sel_timer0 = 4'h4;
				sel_wdog = 4'h3;
			end
			3'h4:
			begin
				sel_timer0 = 4'h5;
				sel_wdog = 4'h4;
			end
			3'h5:
			begin
				sel_timer0 = 4'h6;
				sel_wdog = 4'h5;
			end
			3'h6:
			begin
				sel_timer0 = 4'h7;
				sel_wdog = 4'h6;
			end
			3'h7:
			begin
				sel_timer0 = 4'h8;
				sel_wdog = 4'h7;
			end
			default:
			begin
				sel_timer0 = 4'h1;
				sel_wdog = 4'h0;
			end
		endcase
	end
	assign sel = own_wdog ? sel_wdog : sel_timer0;

	// ****************************************
	// Ripple taps, one per counter bit
	// ****************************************
	// Tap k is high when the low k bits are all ones; tap 0 always
	genvar gi;
	assign tap[0] = 1'b1;
	generate
		for (gi = 1; gi <= CNT_W; gi = gi + 1)
		begin : g_tap
			assign tap[gi] = &cnt_r[gi-1:0];
		end
	endgenerate

	// Divided pulse on the owned tick that wraps the selected bits
	assign div_hit = src_tick & tap[sel];

	// ****************************************
	// Counter next value
	// ****************************************
	// A clear wins over a tick arriving in the same cycle
	// Owner change neither clears nor resyncs the count
	always @*
	begin
		cnt_nxt = cnt_r;
		if (clr)
		begin
			cnt_nxt = `TPS_CNT_RESET;
		end
		else if (src_tick)
		begin
			cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// ****************************************
	// Output next values
	// ****************************************
	// The non-owner passes its source through, one cycle late
	// A clear in the same cycle suppresses the divided tick
	assign timer0_tick_nxt = own_timer0 ? (div_hit & ~clr) :
		timer0_src_tick;
	assign wdog_tick_nxt = own_wdog ? (div_hit & ~clr) :
		wdog_src_tick;
	// The watchdog itself is cleared whoever owns the counter
	assign watchdog_timer_clear_nxt = watchdog_clear_instruction;

	// ****************************************
	// State
	// ****************************************
	// Count is held internally only, no read path exists
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_r <= `TPS_CNT_RESET;
		end
		else if (ce)
		begin
			cnt_r <= cnt_nxt;
		end
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			timer0_tick <= 1'b0;
		end
		else if (ce)
		begin
			timer0_tick <= timer0_tick_nxt;
		end
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wdog_tick <= 1'b0;
		end
		else if (ce)
		begin
			wdog_tick <= wdog_tick_nxt;
		end
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			watchdog_timer_clear <= 1'b0;
		end
		else if (ce)
		begin
			watchdog_timer_clear <= watchdog_timer_clear_nxt;
		end
	end
endmodule

/* File: tps_consts.vh */
// Constants for the shared timer0 / watchdog prescaler
//
// Contract
// - One 8-bit counter, timer0 prescaler or watchdog postscaler
// - Exactly one owner; other side runs undivided
// - Owner bit and 3-bit ratio in option low bits
// - Timer0 count writes clear counter when timer0 owns
// - Watchdog clear resets counter when owned, watchdog always
// - Counter value never readable nor directly loadable
`ifndef TPS_CONSTS_VH
`define TPS_CONSTS_VH

// ****************************************
// Field layout of the option low nibble
// ****************************************
`define TPS_OPT_W 4
`define TPS_OPT_OWNER_BIT 3
`define TPS_OPT_RATIO_HI 2
`define TPS_OPT_RATIO_LO 0
`define TPS_OPT_RESET 4'hf
`define TPS_OWNER_WDOG 1'b1

// ****************************************
// Counter geometry
// ****************************************
`define TPS_CNT_W 8
`define TPS_CNT_RESET 8'h00

`endif

/* File: tps_prescaler_properties.sv */
// Checker of the shared prescaler outputs
`timescale 1ns/1ps
module tps_prescaler_properties(
	input wire clk,
	input wire rst,
	input wire ce,
	input wire [3:0] option_nibble,
	input wire timer0_src_tick,
	input wire wdog_src_tick,
	input wire timer0_count_register_write,
	input wire watchdog_clear_instruction,
	input wire timer0_tick,
	input wire wdog_tick,
	input wire watchdog_timer_clear
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire t0 = ce & ~option_nibble[3];
	wire wd = ce & option_nibble[3];
	a_wdog_free: assert property (t0 |=>
		wdog_tick == $past(wdog_src_tick)) else $error("wdog tick");
	a_t0_free: assert property (wd |=>
		timer0_tick == $past(timer0_src_tick)) else $error("t0 tick");
	a_wr_clears: assert property (t0 && timer0_count_register_write
		|=> !timer0_tick) else $error("t0 write");
	a_clr_pulse: assert property (ce |=>
		watchdog_timer_clear == $past(watchdog_clear_instruction))
		else $error("wdog clear");
	a_t0_cause: assert property (t0 && !timer0_src_tick
		|=> !timer0_tick) else $error("t0 spurious");
	a_wd_cause: assert property (wd && !wdog_src_tick
		|=> !wdog_tick) else $error("wdog spurious");
	// Unity watchdog ratio passes every owned tick not met by a watchdog clear
	sequence s_wd_unity;
		wd && option_nibble[2:0] == 3'h0 && wdog_src_tick
			&& !watchdog_clear_instruction;
	endsequence
	a_wd_unity: assert property (s_wd_unity |=> wdog_tick)
		else $error("wdog unity");
	a_ce_freeze: assert property (!ce |=> $stable(timer0_tick)
		&& $stable(wdog_tick) && $stable(watchdog_timer_clear))
		else $error("ce freeze");
endmodule
bind tps_prescaler tps_prescaler_properties u_props (.*);

/* File: tps_prescaler_tb_top.sv */
// Bench for the shared prescaler
`timescale 1ns/1ps
module tps_prescaler_tb_top;
	reg clk = 0, rst = 1, ts = 0, ws = 0, tw = 0, wc = 0, ce = 1;
	reg [3:0] opt = 4'h0;
	wire tt, wt, wtc;
	integer err_count = 0, comparisons = 0, cyc = 0;
	integer ct = 0, cw = 0, cc = 0;
	always #20 clk = ~clk;
	// Counted mid-cycle, clear of the launching edge
	always @(negedge clk)
	begin
		ct += tt;
		cw += wt;
		cc += wtc;
	end
	tps_prescaler dut (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.option_nibble(opt),
		.timer0_src_tick(ts),
		.wdog_src_tick(ws),
		.timer0_count_register_write(tw),
		.watchdog_clear_instruction(wc),
		.timer0_tick(tt),
		.wdog_tick(wt),
		.watchdog_timer_clear(wtc)
	);
	task test_done;
		if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk)
		if (++cyc > 5000)
		begin
			err_count++;
			test_done;
		end
	task chk(input [15:0] s, input [15:0] e);
		comparisons++;
		if (s !== e)
		begin
			err_count++;
			$display("MISMATCH %0t %h %h", $time, s, e);
		end
	endtask
	task tick(input integer k);
		repeat (k)
		begin
			@(posedge clk) {ts, ws} <= 2'h3;
			@(posedge clk) {ts, ws} <= 2'h0;
		end
		@(posedge clk);
	endtask
	// Both clears at once; the non-owner one must be ignored
	task clr(input [3:0] o);
		@(posedge clk) {opt, tw, wc} <= {o, 2'h3};
		@(posedge clk) {tw, wc} <= 2'h0;
		ct = 0;
		cw = 0;
	endtask
	task s_t0;
		clr(4'h0);
		tick(4);
		chk(ct, 2);
		chk(cw, 4);
	endtask
	task s_wd;
		clr(4'ha);
		tick(8);
		chk(ct, 8);
		chk(cw, 2);
	endtask
	task s_wr;
		clr(4'h1);
		tick(3);
		clr(4'h1);
		tick(3);
		chk(ct, 0);
	endtask
	task s_wc;
		clr(4'h9);
		tick(1);
		clr(4'h9);
		tick(1);
		chk(cw, 0);
	endtask
	// Mid-run reset returns the count to zero
	task s_rst;
		clr(4'h0);
		tick(1);
		@(posedge clk) rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		tick(1);
		chk(ct, 0);
		chk(cw, 2);
	endtask
	// Enable low must freeze count and outputs
	task s_ce;
		clr(4'h0);
		tick(1);
		ce <= 1'b0;
		tick(2);
		ce <= 1'b1;
		tick(1);
		chk(ct, 1);
		chk(cw, 2);
	endtask
	// A clear from the non-owner leaves the count alone
	task s_nc;
		clr(4'h1);
		tick(2);
		cc = 0;
		@(posedge clk) wc <= 1'b1;
		@(posedge clk) wc <= 1'b0;
		tick(2);
		chk(ct, 1);
		chk(cc, 1);
	endtask
	task s_nw;
		clr(4'h9);
		tick(1);
		@(posedge clk) tw <= 1'b1;
		@(posedge clk) tw <= 1'b0;
		tick(1);
		chk(cw, 1);
	endtask
	// Every ratio for both owners, two divided ticks each
	task s_ratio;
		integer n;
		integer d;
		for (n = 0; n < 8; n = n + 1)
		begin
			d = 2 << n;
			clr({1'b0, n[2:0]});
			tick(2 * d);
			chk(ct, 2);
			chk(cw, 2 * d);
			d = 1 << n;
			clr({1'b1, n[2:0]});
			tick(2 * d);
			chk(cw, 2);
			chk(ct, 2 * d);
		end
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 0;
		s_t0;
		s_wd;
		s_wr;
		s_wc;
		s_rst;
		s_ce;
		s_nc;
		s_nw;
		s_ratio;
		test_done;
	end
endmodule
